// ### drc_core.sv
// driver register command path: write/read of per-axis driver registers
// assumes cmdValid is a one-cycle pulse from a same-clock text parser,
// and fault/standstill inputs come from pins (synchronised here)
// How it works
// - every axis driver keeps separate registers
// - driver index 0 selects the X axis
// - data bytes arrive high to low
// - hold current 5 bits, resets to 8
// - hold zero makes standstill freewheel; brake is never selected
// - run current 5 bits, resets to 31
// - reduce after standstill and powerdown wait
// - ramp delay zero drops current instantly
// - ramp steps wait value times 2^18
// - status flags clear by writing one
// - reset flag set after driver reset
// - fault flag set on shutdown event
// - fault flag not clearable while fault active
// - status read holds two meaningful bits, third reads zero
// - read takes index and address, answers two cycles later
// - reply is twelve bytes in order
// - fifth reply byte is sync 0x05
`timescale 1ns/10ps
module drc_core
  import drc_pkg::*;
#(
  parameter int PDWAIT = PDWAIT_CYC,
  parameter int UNIT_LOG2 = DELAY_UNIT_LOG2
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  // command from a same-clock parser
  input  wire logic              cmdValid,
  input  wire drc_cmd_t          cmd,
  // pin levels, two flip-flops before any logic reads them
  input  wire logic [NUM_DRV-1:0] drvResetEvt,
  input  wire logic [NUM_DRV-1:0] faultActive,
  input  wire logic [NUM_DRV-1:0] standstill,
  // all outputs come straight from the state register
  output logic                   replyValid,
  output logic [7:0]             replyByte,
  output logic                   replyLast,
  output logic [NUM_DRV*5-1:0]   motorCurrent,
  output logic [NUM_DRV-1:0]     freewheel
);

  // --------------------------------------------------------------
  // parameter checks
  // --------------------------------------------------------------
  initial begin
    if (NUM_DRV < 1 || NUM_DRV > 256)
      $error("drc_core: driver count out of range");
    if (UNIT_LOG2 < 1 || UNIT_LOG2 > 18)
      $error("drc_core: ramp unit out of range");
    // the power-down counter is 23 bits wide
    if (PDWAIT < 1 || PDWAIT > 8_000_000)
      $error("drc_core: power-down wait out of range");
  end

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, SEND} drc_st_t;

  typedef struct packed {
    drc_drv_t [NUM_DRV-1:0] drv;
    logic [NUM_DRV-1:0]     rstS1, rstS2, rstS3;
    logic [NUM_DRV-1:0]     fltS1, fltS2, fltS3;
    logic [NUM_DRV-1:0]     stS1, stS2;
    drc_st_t                st;
    logic [3:0]             idx;
    logic [REPLY_LEN-1:0][7:0] frame;
    logic                   replyValid;
    logic [7:0]             replyByte;
    logic                   replyLast;
    logic [NUM_DRV*5-1:0]   motorCurrent;
    logic [NUM_DRV-1:0]     freewheel;
    logic [NUM_DRV-1:0]     brakeSel;
  } drc_state_t;

  drc_state_t s_r, s_nxt;

  function automatic logic [31:0] regView(input drc_drv_t d, input logic [6:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == ADDR_GSTATUS) begin
      v[2:0] = d.global_status_flags;
    end else if (a == ADDR_HOLDRUN) begin
      v[HOLD_LSB+:5]  = d.holdCurrent;
      v[RUN_LSB+:5]   = d.runCurrent;
      v[DELAY_LSB+:4] = d.holdRampDelay;
    end
    return v;
  endfunction : regView

  function automatic drc_drv_t drvReset(input drc_drv_t d);
    drc_drv_t r;
    r = d;
    r.holdCurrent   = HOLD_RST;
    r.runCurrent    = RUN_RST;
    r.holdRampDelay = DELAY_RST;
    r.actCurrent    = RUN_RST;
    r.rampCnt       = '0;
    r.pdCnt         = '0;
    return r;
  endfunction : drvReset

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // write-one-to-clear: a zero in the write leaves the flag alone
  function automatic logic w1c(input logic flag, input logic wr);
    return flag & ~wr;
  endfunction : w1c

  // apply one host write to a driver record; unknown addresses fall through
  function automatic drc_drv_t regWrite(input drc_drv_t d, input logic [6:0] a,
                                        input logic [31:0] v, input logic faultOn);
    drc_drv_t r;
    r = d;
    if (a == ADDR_HOLDRUN) begin
      r.holdCurrent   = v[HOLD_LSB+:5];
      r.runCurrent    = v[RUN_LSB+:5];
      r.holdRampDelay = v[DELAY_LSB+:4];
    end else if (a == ADDR_GSTATUS) begin
      r.global_status_flags[0] = w1c(d.global_status_flags[0], v[0]);
      // fault flag sticks while the fault is still present
      if (!faultOn)
        r.global_status_flags[1] = w1c(d.global_status_flags[1], v[1]);
    end
    return r;
  endfunction : regWrite

  // true once the ramp has waited a full step of delay units
  function automatic logic rampDue(input logic [21:0] cnt, input logic [3:0] dly,
                                  input logic [22:0] unit);
    logic [22:0] lim;
    lim = 23'(unit * 23'(dly));
    return 22'(cnt + 22'd1) >= lim[21:0];
  endfunction : rampDue

  // plain 8-bit sum of the driver's part of the reply; wraps on purpose
  function automatic logic [7:0] replySum(input logic [6:0] a, input logic [31:0] v);
    logic [7:0] acc;
    acc = REPLY_SYNC + MASTER_ADDR;
    acc = acc + {1'b0, a};
    acc = acc + v[31:24];
    acc = acc + v[23:16];
    acc = acc + v[15:8];
    acc = acc + v[7:0];
    return acc;
  endfunction : replySum

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic [7:0] sel;
    logic [31:0] rv;
    logic [22:0] unitLen;
    s_nxt = s_r;
    sel = cmd.drv;
    rv = 32'h0000_0000;
    unitLen = 23'(1) << UNIT_LOG2;
    s_nxt.rstS1 = drvResetEvt;
    s_nxt.rstS2 = s_r.rstS1;
    s_nxt.rstS3 = s_r.rstS2;
    s_nxt.fltS1 = faultActive;
    s_nxt.fltS2 = s_r.fltS1;
    s_nxt.fltS3 = s_r.fltS2;
    s_nxt.stS1  = standstill;
    s_nxt.stS2  = s_r.stS1;
    s_nxt.replyValid = 1'b0;
    s_nxt.replyLast  = 1'b0;

    // ------------------------------------------------------------
    // host writes: only the addressed driver changes
    // ------------------------------------------------------------
    for (int i = 0; i < NUM_DRV; i++) begin
      if (cmdValid && cmd.isWrite && sel == 8'(i) && cmd.reg8[WR_BIT]) begin
        s_nxt.drv[i] = regWrite(s_r.drv[i], cmd.reg8[6:0], cmd.data, s_r.fltS2[i]);
      end
    end

    // ------------------------------------------------------------
    // status events: a set wins over a clear in the same cycle
    // ------------------------------------------------------------
    for (int i = 0; i < NUM_DRV; i++) begin
      if (s_r.rstS2[i] && !s_r.rstS3[i]) begin
        s_nxt.drv[i] = drvReset(s_nxt.drv[i]);
        s_nxt.drv[i].global_status_flags[0] = 1'b1;
      end
      if (s_r.fltS2[i] && !s_r.fltS3[i])
        s_nxt.drv[i].global_status_flags[1] = 1'b1;
      // no third flag source here, so the bit always reads zero
      s_nxt.drv[i].global_status_flags[2] = 1'b0;
    end

    // ------------------------------------------------------------
    // current control: run while moving, ramp to hold at rest
    // ------------------------------------------------------------
    for (int i = 0; i < NUM_DRV; i++) begin
      if (!s_r.stS2[i]) begin
        s_nxt.drv[i].actCurrent = s_nxt.drv[i].runCurrent;
        s_nxt.drv[i].pdCnt   = '0;
        s_nxt.drv[i].rampCnt = '0;
      end else if (s_r.drv[i].pdCnt < 23'(PDWAIT)) begin
        s_nxt.drv[i].pdCnt = s_r.drv[i].pdCnt + 23'd1;
      end else if (s_r.drv[i].actCurrent > s_r.drv[i].holdCurrent) begin
        if (s_r.drv[i].holdRampDelay == 4'h0) begin
          s_nxt.drv[i].actCurrent = s_r.drv[i].holdCurrent;
        end else if (rampDue(s_r.drv[i].rampCnt, s_r.drv[i].holdRampDelay, unitLen)) begin
          s_nxt.drv[i].rampCnt    = '0;
          s_nxt.drv[i].actCurrent = s_r.drv[i].actCurrent - 5'd1;
        end else begin
          s_nxt.drv[i].rampCnt = s_r.drv[i].rampCnt + 22'd1;
        end
      end else begin
        s_nxt.drv[i].actCurrent = s_r.drv[i].holdCurrent;
      end
      s_nxt.motorCurrent[i*5+:5] = s_r.drv[i].actCurrent;
      // zero hold current: idle the bridge and freewheel, brakeSel is never set
      s_nxt.freewheel[i] = s_r.stS2[i] && s_r.drv[i].actCurrent == 5'h00
                           && !s_r.brakeSel[i];
    end

    // ------------------------------------------------------------
    // reply framer: one byte per cycle, reads dropped while busy
    // ------------------------------------------------------------
    unique case (s_r.st)
      IDLE: begin
        if (cmdValid && !cmd.isWrite) begin
          for (int i = 0; i < NUM_DRV; i++)
            if (sel == 8'(i))
              rv = regView(s_r.drv[i], cmd.reg8[6:0]);
          if (sel == 8'(NUM_DRV) && cmd.reg8[6:0] == ADDR_GSTATUS)
            rv = 32'h0000_0000;
          s_nxt.frame[0]  = REPLY_SYNC;
          s_nxt.frame[1]  = sel;
          s_nxt.frame[2]  = {1'b0, cmd.reg8[6:0]};
          s_nxt.frame[3]  = 8'h00;
          s_nxt.frame[4]  = REPLY_SYNC;
          s_nxt.frame[5]  = MASTER_ADDR;
          s_nxt.frame[6]  = {1'b0, cmd.reg8[6:0]};
          s_nxt.frame[7]  = rv[31:24];
          s_nxt.frame[8]  = rv[23:16];
          s_nxt.frame[9]  = rv[15:8];
          s_nxt.frame[10] = rv[7:0];
          // simple sum stands in for the driver's own datagram check
          s_nxt.frame[11] = replySum(cmd.reg8[6:0], rv);
          s_nxt.idx = 4'h0;
          s_nxt.st  = SEND;
        end
      end
      SEND: begin
        s_nxt.replyValid = 1'b1;
        s_nxt.replyByte  = s_r.frame[s_r.idx];
        s_nxt.replyLast  = s_r.idx == 4'(REPLY_LEN-1);
        s_nxt.idx = s_r.idx + 4'h1;
        if (s_r.idx == 4'(REPLY_LEN-1))
          s_nxt.st = IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // constants only, so the async branch stays glitch free
      s_r <= '0;
      for (int i = 0; i < NUM_DRV; i++) begin
        s_r.drv[i].holdCurrent   <= HOLD_RST;
        s_r.drv[i].runCurrent    <= RUN_RST;
        s_r.drv[i].holdRampDelay <= DELAY_RST;
        s_r.drv[i].global_status_flags         <= GLOBAL_STATUS_FLAGS_RST;
        s_r.drv[i].actCurrent    <= RUN_RST;
        s_r.motorCurrent[i*5+:5] <= RUN_RST;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign replyValid   = s_r.replyValid;
  assign replyByte    = s_r.replyByte;
  assign replyLast    = s_r.replyLast;
  assign motorCurrent = s_r.motorCurrent;
  assign freewheel    = s_r.freewheel;

endmodule : drc_core

// ### drc_pkg.sv
// shared constants and carrier types for the driver register command block
// assumes one 20 MHz clock and commands already parsed into bytes upstream
package drc_pkg;

  localparam int          CLK_HZ          = 20_000_000;
  localparam int          NUM_DRV         = 4;
  localparam logic [6:0]  ADDR_GSTATUS    = 7'h01;
  localparam logic [6:0]  ADDR_HOLDRUN    = 7'h10;
  localparam int          WR_BIT          = 7;
  localparam logic [7:0]  REPLY_SYNC      = 8'h05;
  localparam logic [7:0]  MASTER_ADDR     = 8'hFF;
  localparam int          REPLY_LEN       = 12;
  localparam int          HOLD_LSB        = 0;
  localparam int          RUN_LSB         = 8;
  localparam int          DELAY_LSB       = 16;
  localparam logic [4:0]  HOLD_RST        = 5'h08;
  localparam logic [4:0]  RUN_RST         = 5'h1F;
  localparam logic [3:0]  DELAY_RST       = 4'h1;
  localparam int          DELAY_UNIT_LOG2 = 18;
  localparam logic [2:0]  GLOBAL_STATUS_FLAGS_RST       = 3'h1;
  localparam int          PDWAIT_CYC      = 2_000_000;

  // one parsed text command
  typedef struct packed {
    logic       isWrite;
    logic [7:0] drv;
    logic [7:0] reg8;
    logic [31:0] data;
  } drc_cmd_t;

  // one axis driver's live state
  typedef struct packed {
    logic [4:0]  holdCurrent;
    logic [4:0]  runCurrent;
    logic [3:0]  holdRampDelay;
    logic [2:0]  global_status_flags;
    logic [4:0]  actCurrent;
    logic [21:0] rampCnt;
    logic [22:0] pdCnt;
  } drc_drv_t;

endpackage : drc_pkg

// ### drc_core_asserts.sv
// port checker for the driver register command block
// assumes one clock, bound onto drc_core
`timescale 1ns/10ps
module drc_core_asserts
  import drc_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic                 cmdValid,
  input wire drc_cmd_t             cmd,
  input wire logic                 replyValid,
  input wire logic [7:0]           replyByte,
  input wire logic                 replyLast,
  input wire logic [NUM_DRV*5-1:0] motorCurrent,
  input wire logic [NUM_DRV-1:0]   freewheel
);
  // ------------------------------------------------------------
  // reply framing and current outputs
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_reply_len: assert property (
    $rose(replyValid) |-> replyValid[*8] ##1 replyValid[*4] ##0 replyLast) else $error("bad len");
  chk_read_start: assert property (
    $rose(replyValid) |-> $past(cmdValid, 2) && !$past(cmd.isWrite, 2)) else $error("bad start");
  chk_drv_echo: assert property (
    $rose(replyValid) |=> replyByte == $past(cmd.drv, 3)) else $error("bad drv echo");
  chk_sync_byte: assert property (
    $rose(replyValid) |-> ##4 replyByte == REPLY_SYNC) else $error("bad sync");
  chk_master_addr: assert property (
    $rose(replyValid) |-> ##5 replyByte == MASTER_ADDR ##1 replyByte == $past(cmd.reg8, 8))
    else $error("bad addr");
  chk_last_gap: assert property (
    replyLast |-> replyValid ##1 !replyValid) else $error("bad last");
  chk_free_zero: assert property (
    freewheel[0] |-> motorCurrent[4:0] == 5'h00) else $error("freewheel with current");
  chk_reset_cur: assert property (
    $rose(rst_n) |-> motorCurrent == {NUM_DRV{RUN_RST}} && !replyValid) else $error("bad reset");
  cover property ($rose(replyValid));
  cover property (replyLast);
  cover property ($rose(freewheel[0]));
endmodule : drc_core_asserts
bind drc_core drc_core_asserts u_chk (.clock(clock), .rst_n(rst_n), .cmdValid(cmdValid),
  .cmd(cmd), .replyValid(replyValid), .replyByte(replyByte), .replyLast(replyLast),
  .motorCurrent(motorCurrent), .freewheel(freewheel));

// ### drc_host.sv
// host model issuing parsed commands and collecting reply bytes
// assumes a reply ends within 16 cycles of the read being taken
`timescale 1ns/10ps
module drc_host
  import drc_pkg::*;
(
  input  wire logic       clock,
  output drc_cmd_t        cmd,
  output logic            cmdValid,
  input  wire logic       replyValid,
  input  wire logic [7:0] replyByte
);
  // ------------------------------------------------------------
  // command tasks
  // ------------------------------------------------------------
  logic [7:0] rb [12];
  int         n;
  initial begin
    cmdValid = 1'b0;
    cmd      = '0;
  end
  task automatic send(input logic w, input logic [7:0] d, input logic [6:0] a,
                      input logic [31:0] v);
    @(posedge clock);
    #1;
    cmdValid    = 1'b1;
    cmd.isWrite = w;
    cmd.drv     = d;
    cmd.reg8    = {w, a};
    cmd.data    = v;
    @(posedge clock);
    #1;
    cmdValid = 1'b0;
    cmd      = ~cmd; // released fields never keep their last value
  endtask : send
  task automatic rd(input logic [7:0] d, input logic [6:0] a);
    send(1'b0, d, a, 32'h0);
    n = 0;
    repeat (16) begin
      // mid-cycle sampling keeps clear of the edge that launches each byte
      @(negedge clock);
      if (replyValid === 1'b1 && n < 12) begin
        rb[n] = replyByte;
        n++;
      end
    end
  endtask : rd
endmodule : drc_host

// ### tb.sv
// self-checking bench for the driver register command block
// assumes shortened power-down and ramp counts set below
`timescale 1ns/10ps
module tb
  import drc_pkg::*;
;
  logic                 clock, rst_n, cmdValid, replyValid, replyLast;
  drc_cmd_t             cmd;
  logic [NUM_DRV-1:0]   drvResetEvt, faultActive, standstill, freewheel;
  logic [7:0]           replyByte, sum;
  logic [NUM_DRV*5-1:0] motorCurrent;
  int                   err_count, comparisons;
  drc_core #(.PDWAIT(20), .UNIT_LOG2(2)) DUT (.clock(clock), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmd(cmd), .drvResetEvt(drvResetEvt), .faultActive(faultActive), .standstill(standstill),
    .replyValid(replyValid), .replyByte(replyByte), .replyLast(replyLast),
    .motorCurrent(motorCurrent), .freewheel(freewheel));
  drc_host host (.clock(clock), .cmd(cmd), .cmdValid(cmdValid), .replyValid(replyValid),
    .replyByte(replyByte));
  // ------------------------------------------------------------
  // helpers and scenarios
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [4:0] mc(input int i);
    return motorCurrent[5*i+:5];
  endfunction : mc
  task automatic st(input int d, input logic [2:0] e);
    host.rd(d[7:0], ADDR_GSTATUS);
    chk("len", REPLY_LEN, host.n);
    chk("global_status_flags", {5'h00, e}, host.rb[10]);
  endtask : st
  task automatic t_reset;
    for (int d = 0; d < NUM_DRV; d++) begin
      chk("cur", RUN_RST, mc(d));
      st(d, GLOBAL_STATUS_FLAGS_RST);
      sum = 8'h00;
      for (int k = 4; k < 11; k++) sum += host.rb[k];
      chk("echo", d, host.rb[1]);
      chk("sync", REPLY_SYNC, host.rb[4]);
      chk("addr", {MASTER_ADDR, 8'h01}, {host.rb[5], host.rb[6]});
      chk("sum", sum, host.rb[11]);
    end
  endtask : t_reset
  task automatic t_clear;
    host.send(1'b1, 8'h00, ADDR_GSTATUS, 32'h0);
    st(0, 3'h1);
    host.send(1'b1, 8'h00, ADDR_GSTATUS, 32'h1);
    st(0, 3'h0);
    st(1, 3'h1);
    drvResetEvt[0] = 1'b1;
    repeat (4) @(posedge clock);
    #1 drvResetEvt[0] = 1'b0;
    st(0, 3'h1);
  endtask : t_clear
  task automatic t_fault;
    faultActive[1] = 1'b1;
    repeat (4) @(posedge clock);
    st(1, 3'h3);
    host.send(1'b1, 8'h01, ADDR_GSTATUS, 32'h3);
    st(1, 3'h2);
    #1 faultActive[1] = 1'b0;
    repeat (4) @(posedge clock);
    host.send(1'b1, 8'h01, ADDR_GSTATUS, 32'h2);
    st(1, 3'h0);
  endtask : t_fault
  task automatic t_current;
    host.send(1'b1, 8'h00, ADDR_HOLDRUN, 32'h0000_0A00);
    host.send(1'b1, 8'h02, ADDR_HOLDRUN, 32'h000F_1F08);
    repeat (4) @(posedge clock);
    chk("run0", 5'h0A, mc(0));
    chk("run1", RUN_RST, mc(1));
    #1 standstill = 4'hF;
    repeat (12) @(posedge clock);
    chk("wait1", RUN_RST, mc(1));
    repeat (200) @(posedge clock);
    chk("hold0", 5'h00, {mc(0), freewheel[0]} ^ 6'h01);
    chk("hold1", HOLD_RST, mc(1));
    chk("slow2", 1, mc(2) >= 5'd27 && mc(2) <= 5'd30);
  endtask : t_current
  task automatic final_report;
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    final_report();
  end
  initial begin
    {rst_n, drvResetEvt, faultActive, standstill} = '0;
    err_count   = 0;
    comparisons = 0;
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    t_reset();
    t_clear();
    t_fault();
    t_current();
    final_report();
  end
endmodule : tb
